/* include/ouv_cfg.svh */
/*
 * Constants of the output under-voltage fault handler: command codes,
 * field positions, reset values and response encodings.
 * Assumes a PMBus front end that decodes transfers into command pulses.
 */
// Behaviour
// - keep a 16-bit read/write under-voltage threshold, word access, unsigned.
// - keep a read/write reaction byte; bits 7:6 pick the fault response.
// - response 00 keeps the output running through a fault.
// - response 01 runs on for the delay, then applies retry if fault remains.
// - response 10 disables the output at once, then follows the retry count.
// - response 11 holds output off while fault is present, resumes after.
// - clear-faults, status clear, reset or off-then-on clears a latched fault.
// - retry field bits 5:3; zero means stay off until cleared.
// - retry 1 to 6 tries that many restarts, then latches off.
// - retry 7 restarts without limit.
// - time between restart starts equals the delay count in units.
// - delay field gives two to the field value units, unit from elsewhere.
// - endless retry stops on off command, bias loss or another fault.
`ifndef OUV_CFG_SVH
`define OUV_CFG_SVH
// ***********************************************
// command codes and reset values
// ***********************************************
`define OUV_CODE_THR 8'h44
`define OUV_CODE_REACT 8'h45
`define OUV_THR_RST 16'h0000
`define OUV_REACT_RST 8'h00
// ***********************************************
// reaction byte fields
// ***********************************************
`define OUV_RESP_HI 7
`define OUV_RESP_LO 6
`define OUV_RETRY_HI 5
`define OUV_RETRY_LO 3
`define OUV_DLY_HI 2
`define OUV_DLY_LO 0
`define OUV_RESP_IGNORE 2'h0
`define OUV_RESP_RUNON 2'h1
`define OUV_RESP_SHUT 2'h2
`define OUV_RESP_HOLD 2'h3
`define OUV_RETRY_NONE 3'h0
`define OUV_RETRY_FOREVER 3'h7
`define OUV_ONE_UNIT 8'h01
`define OUV_TRY_ZERO 3'h0
`define OUV_TRY_STEP 3'h1
`endif

/* include/ouv_pkg.sv */
/*
 * Types of the output under-voltage fault handler.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package ouv_pkg;
  // handler states
  typedef enum logic [2:0] {
    ST_OFF, ST_RUN, ST_RUNON, ST_WAIT, ST_TRY, ST_LATCH, ST_HOLD
  } ouv_state_type;

  // one decoded bus transfer
  typedef struct packed {
    logic [7:0] code;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } ouv_cmd_type;

  // fault clearing and power control requests
  typedef struct packed {
    logic on_cmd;
    logic clear_faults;
    logic status_clr;
    logic other_shutdown;
  } ouv_ctrl_type;
endpackage : ouv_pkg
`default_nettype wire

/* rtl/ouv_fault.sv */
/*
 * Output under-voltage fault handler: threshold and reaction registers,
 * fault detection, run-on delay, retry sequencing and latch-off.
 * Assumes a PMBus front end giving one-cycle command pulses, a measured
 * output voltage in the same number format as the threshold, and a
 * one-cycle delay-unit tick from the delay-unit prescaler.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ouv_cfg.svh"

module ouv_fault (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // decoded PMBus transfers
  input wire ouv_pkg::ouv_cmd_type i_cmd,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  // control requests
  input wire ouv_pkg::ouv_ctrl_type i_ctrl,
  // measurement and timing
  input wire logic [15:0] i_vout,
  input wire logic i_unit_tick,
  // power stage and status
  output logic o_output_en,
  output logic o_uv_fault
);
  import ouv_pkg::*;

  // ***********************************************
  // registers
  // ***********************************************
  logic [15:0] thr_q, thr_d;
  logic [7:0] react_q, react_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  // host writes and reads of the two settings
  always_comb begin
    thr_d = thr_q;
    react_d = react_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (i_cmd.wr && i_cmd.code == `OUV_CODE_THR) begin
      thr_d = i_cmd.wdata;
    end
    if (i_cmd.wr && i_cmd.code == `OUV_CODE_REACT) begin
      react_d = i_cmd.wdata[7:0];
    end
    if (i_cmd.rd) begin
      // unmapped codes answer nothing; the front end sees no rvalid
      if (i_cmd.code == `OUV_CODE_THR) begin
        rdata_d = thr_q;
        rvalid_d = 1'b1;
      end else if (i_cmd.code == `OUV_CODE_REACT) begin
        rdata_d = {8'h00, react_q};
        rvalid_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      thr_q <= `OUV_THR_RST;
      react_q <= `OUV_REACT_RST;
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      thr_q <= thr_d;
      react_q <= react_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;

  // ***********************************************
  // fields and conditions
  // ***********************************************
  logic [1:0] resp;
  logic [2:0] retry;
  logic [2:0] dly;
  logic [7:0] dly_units;
  logic uv;
  logic off_evt;
  logic clr;

  // reaction byte fields
  assign resp = react_q[`OUV_RESP_HI:`OUV_RESP_LO];
  assign retry = react_q[`OUV_RETRY_HI:`OUV_RETRY_LO];
  assign dly = react_q[`OUV_DLY_HI:`OUV_DLY_LO];
  // two to the field value, so 7 gives 128 units
  assign dly_units = `OUV_ONE_UNIT << dly;
  // unsigned compare, both in the output-voltage format
  assign uv = i_vout < thr_q;
  // off command, or another fault class shutting the unit down
  assign off_evt = !i_ctrl.on_cmd || i_ctrl.other_shutdown;
  assign clr = i_ctrl.clear_faults || i_ctrl.status_clr;

  // ***********************************************
  // response sequencer
  // ***********************************************
  ouv_state_type state_q, state_d;
  logic [7:0] timer_q, timer_d;
  logic [2:0] tries_q, tries_d;
  logic out_q, out_d;
  logic expire;
  logic load;
  logic more;

  // the timer ends on the tick that consumes its last unit
  assign expire = i_unit_tick && timer_q == `OUV_ONE_UNIT;
  // another restart allowed: endless, or count not yet reached
  assign more = retry == `OUV_RETRY_FOREVER || tries_q < retry;

  always_comb begin
    state_d = state_q;
    tries_d = tries_q;
    load = 1'b0;
    if (off_evt) begin
      // commanding off ends every sequence, retries included
      state_d = ST_OFF;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          // off then on again clears any latched fault
          state_d = ST_RUN;
        end
        ST_RUN: begin
          if (uv) begin
            unique case (resp)
              `OUV_RESP_IGNORE: state_d = ST_RUN;
              `OUV_RESP_RUNON: begin
                state_d = ST_RUNON;
                load = 1'b1;
              end
              `OUV_RESP_SHUT: begin
                tries_d = `OUV_TRY_ZERO;
                if (retry == `OUV_RETRY_NONE) begin
                  state_d = ST_LATCH;
                end else begin
                  state_d = ST_WAIT;
                  load = 1'b1;
                end
              end
              `OUV_RESP_HOLD: state_d = ST_HOLD;
            endcase
          end
        end
        ST_RUNON: begin
          if (clr || !uv) begin
            state_d = ST_RUN;
          end else if (expire) begin
            // fault outlived the run-on delay: apply retry setting
            tries_d = `OUV_TRY_ZERO;
            if (retry == `OUV_RETRY_NONE) begin
              state_d = ST_LATCH;
            end else begin
              state_d = ST_WAIT;
              load = 1'b1;
            end
          end
        end
        ST_WAIT: begin
          if (clr) begin
            state_d = ST_RUN;
          end else if (expire) begin
            state_d = ST_TRY;
            tries_d = tries_q + `OUV_TRY_STEP;
            load = 1'b1;
          end
        end
        ST_TRY: begin
          if (clr) begin
            state_d = ST_RUN;
          end else if (expire) begin
            if (!uv) begin
              state_d = ST_RUN;
            end else if (more) begin
              // next attempt starts one delay after the last start
              state_d = ST_TRY;
              tries_d = tries_q + `OUV_TRY_STEP;
              load = 1'b1;
            end else begin
              state_d = ST_LATCH;
            end
          end
        end
        ST_LATCH: begin
          if (clr) begin
            state_d = ST_RUN;
          end
        end
        ST_HOLD: begin
          // no latch here: output returns as soon as the fault goes
          if (!uv) begin
            state_d = ST_RUN;
          end
        end
        default: state_d = ST_OFF; // unused code: fail safe, output off
      endcase
    end
    // retry endless mode lets the count wrap; only more looks at it
    timer_d = timer_q;
    if (load) begin
      timer_d = dly_units;
    end else if (i_unit_tick && timer_q != 8'h00) begin
      timer_d = timer_q - `OUV_ONE_UNIT;
    end
    out_d = state_d == ST_RUN || state_d == ST_RUNON ||
            state_d == ST_TRY;
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_OFF;
      timer_q <= 8'h00;
      tries_q <= `OUV_TRY_ZERO;
      out_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      tries_q <= tries_d;
      out_q <= out_d;
    end
  end

  assign o_output_en = out_q;

  // ***********************************************
  // status bit
  // ***********************************************
  logic sts_q, sts_d;

  // sticky; a fault in the clearing cycle still sets the bit
  always_comb begin
    sts_d = sts_q;
    if (clr || off_evt) begin
      sts_d = 1'b0;
    end
    if (uv && out_q) begin
      sts_d = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sts_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
    end
  end

  assign o_uv_fault = sts_q;

  // ***********************************************
  // checks
  // ***********************************************
  chk_thr_write: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    i_cmd.wr && i_cmd.code == `OUV_CODE_THR |=>
      thr_q == $past(i_cmd.wdata))
    else $error("threshold write not stored");

  chk_react_read: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    i_cmd.rd && !i_cmd.wr && i_cmd.code == `OUV_CODE_REACT |=>
      o_rvalid && o_rdata == {8'h00, react_q})
    else $error("reaction read wrong");

  chk_ignore_runs: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    state_q == ST_RUN && resp == `OUV_RESP_IGNORE && !off_evt |=>
      o_output_en)
    else $error("ignore mode dropped output");

  chk_runon_keeps: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    state_q == ST_RUN && uv && resp == `OUV_RESP_RUNON &&
      !off_evt |=> o_output_en && timer_q == $past(dly_units))
    else $error("run-on did not start delay");

  chk_shut_now: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    state_q == ST_RUN && uv && resp == `OUV_RESP_SHUT |=>
      !o_output_en)
    else $error("shutdown not immediate");

  chk_hold_off: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    state_q == ST_HOLD && !off_evt |=> o_output_en == !$past(uv))
    else $error("hold mode output wrong");

  chk_clear_resume: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    state_q == ST_LATCH && clr && !off_evt |=> o_output_en)
    else $error("clear did not release latch");

  chk_latch_stays: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    state_q == ST_LATCH && !clr |=> !o_output_en)
    else $error("latched output came back");

  chk_try_limit: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    state_q == ST_TRY && retry != `OUV_RETRY_FOREVER |->
      tries_q <= retry)
    else $error("too many restart attempts");

  chk_retry_gap: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    state_q == ST_WAIT && state_d == ST_TRY |=>
      timer_q == dly_units && o_output_en)
    else $error("retry interval not reloaded");

  chk_off_stops: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    off_evt |=> !o_output_en && state_q == ST_OFF)
    else $error("off command did not stop");

  chk_sts_set: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    uv && o_output_en |=> o_uv_fault)
    else $error("fault status not set");

endmodule : ouv_fault
`default_nettype wire

/* verif/ouv_host.sv */
/*
 * Host model for the under-voltage handler: launches decoded bus
 * transfers and control requests one cycle after they are asked for.
 * Assumes the bench asks with one-cycle pulses on i_req and held levels on i_ask.
 */
`timescale 1ns/1ns
`default_nettype none

module ouv_host (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // requests from the bench
  input wire ouv_pkg::ouv_cmd_type i_req,
  input wire ouv_pkg::ouv_ctrl_type i_ask,
  // towards the handler
  output var ouv_pkg::ouv_cmd_type o_cmd,
  output var ouv_pkg::ouv_ctrl_type o_ctrl
);
  import ouv_pkg::*;
  // *********
  // launch
  // *********
  // idle fields flip so stale data is never reused
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cmd <= '0;
      o_ctrl <= '0;
    end else begin
      o_cmd <= i_req;
      o_ctrl <= i_ask;
      if (!(i_req.wr || i_req.rd)) begin
        o_cmd.code <= ~o_cmd.code;
        o_cmd.wdata <= ~o_cmd.wdata;
      end else if (!i_req.wr) begin
        o_cmd.wdata <= ~o_cmd.wdata;
      end
    end
  end
endmodule : ouv_host
`default_nettype wire

/* verif/ouv_fault_test.sv */
/*
 * Self-checking bench of the under-voltage handler.
 * Assumes ouv_host as bus partner and a tick every other cycle.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ouv_cfg.svh"

module ouv_fault_test;
  import ouv_pkg::*;
  localparam ouv_ctrl_type k_on = 4'h8;
  localparam ouv_ctrl_type k_clr = 4'hC;
  localparam ouv_ctrl_type k_sclr = 4'hA;
  localparam ouv_ctrl_type k_shut = 4'h9;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic tick = 1'b0;
  logic [15:0] vout = 16'hFFFF;
  ouv_cmd_type req = '0;
  ouv_ctrl_type ask = k_on;
  ouv_cmd_type cmd;
  ouv_ctrl_type ctl;
  logic [15:0] rdata;
  logic rvalid, out_en, uv_flag;
  int miscompares = 0;
  int samples_checked = 0;
  int hi_ticks = 0;
  logic [31:0] seed = 32'h04CD;
  logic [31:0] v;

  // *********
  // clock, tick and partner
  // *********
  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) tick <= ~tick;
  // ticks seen while the output is on, pre-edge values
  always @(posedge i_mclk) if (tick === 1'b1 && out_en === 1'b1)
    hi_ticks <= hi_ticks + 1;

  ouv_host host (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_req(req),
    .i_ask(ask), .o_cmd(cmd), .o_ctrl(ctl));
  ouv_fault dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_cmd(cmd),
    .o_rdata(rdata), .o_rvalid(rvalid), .i_ctrl(ctl), .i_vout(vout),
    .i_unit_tick(tick), .o_output_en(out_en), .o_uv_fault(uv_flag));

  // *********
  // helpers
  // *********
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // each restart attempt keeps the output up for 2**d delay units
  function automatic int on_ticks(input int tries, input int d);
    return tries << d;
  endfunction : on_ticks

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_lvl(input logic got, input logic exp);
    chk_reg({15'h0000, got}, {15'h0000, exp});
  endtask : chk_lvl

  task automatic put(input logic [7:0] c, input logic w,
                     input logic [15:0] d);
    @(posedge i_mclk);
    req <= '{c, w, ~w, d};
    @(posedge i_mclk);
    req <= '0;
  endtask : put

  // a read answers once, and only for mapped codes
  task automatic rd(input logic [7:0] c, input logic [15:0] exp,
                    input logic hit);
    logic seen;
    seen = 1'b0;
    put(c, 1'b0, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      @(posedge i_mclk);
      #1;
      if (rvalid === 1'b1 && !seen) begin
        seen = 1'b1;
        if (hit) chk_reg(rdata, exp);
        chk_lvl(k == 0, 1'b1);
      end
    end
    chk_lvl(seen, hit);
  endtask : rd

  task automatic pulse(input ouv_ctrl_type p, input int n);
    @(posedge i_mclk);
    ask <= p;
    repeat (n) @(posedge i_mclk);
    ask <= k_on;
  endtask : pulse

  // program a reaction, pull the output low, count on-ticks; hi<0 skips
  task automatic go(input logic [1:0] r, input logic [2:0] n,
                    input logic [2:0] d, input int w, input int hi,
                    input logic out);
    int base;
    put(`OUV_CODE_REACT, 1'b1, {8'h00, r, n, d});
    @(posedge i_mclk);
    vout <= 16'h7FFF;
    @(posedge i_mclk);
    #1;
    base = hi_ticks;
    repeat (w) @(posedge i_mclk);
    #1;
    if (hi >= 0) chk_reg(16'(hi_ticks - base), 16'(hi));
    chk_lvl(out_en, out);
    chk_lvl(uv_flag, 1'b1);
  endtask : go

  task automatic heal(input ouv_ctrl_type p);
    @(posedge i_mclk);
    vout <= 16'hFFFF;
    pulse(p, 1);
    repeat (3) @(posedge i_mclk);
    #1;
    chk_lvl(out_en, 1'b1);
  endtask : heal

  // *********
  // main sequence
  // *********
  initial begin
    int d;
    repeat (4) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rd(`OUV_CODE_THR, `OUV_THR_RST, 1'b1);
    rd(`OUV_CODE_REACT, {8'h00, `OUV_REACT_RST}, 1'b1);
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      put(`OUV_CODE_THR, 1'b1, v[15:0]);
      put(`OUV_CODE_REACT, 1'b1, v[31:16]);
      rd(`OUV_CODE_THR, v[15:0], 1'b1);
      rd(`OUV_CODE_REACT, {8'h00, v[23:16]}, 1'b1);
    end
    rd(8'h46, 16'h0000, 1'b0);
    put(`OUV_CODE_THR, 1'b1, 16'h8000);
    put(`OUV_CODE_REACT, 1'b1, 16'h0000);
    @(posedge i_mclk);
    vout <= 16'h8000;
    repeat (5) @(posedge i_mclk);
    #1;
    chk_lvl(uv_flag, 1'b0);
    go(2'h0, 3'h0, 3'h0, 40, 20, 1'b1);
    heal(k_sclr);
    chk_lvl(uv_flag, 1'b0);
    go(2'h3, 3'h0, 3'h0, 10, 0, 1'b0);
    heal(k_on);
    for (int n = 0; n < 7; n++) begin
      d = (n == 6) ? 7 : int'(rnd() % 4);
      go(2'h2, 3'(n), 3'(d), ((n + 2) << (d + 1)) + 20, on_ticks(n, d),
        1'b0);
      heal(n[0] ? k_sclr : k_clr);
    end
    d = int'(rnd() % 4);
    go(2'h1, 3'h0, 3'(d), (3 << (d + 1)) + 20, on_ticks(1, d),
      1'b0);
    heal(k_clr);
    go(2'h2, 3'h7, 3'h0, 200, -1, 1'b1);
    pulse('0, 4);
    #1;
    chk_lvl(out_en, 1'b0);
    heal(k_on);
    chk_lvl(uv_flag, 1'b0);
    go(2'h2, 3'h7, 3'h0, 60, -1, 1'b1);
    pulse(k_shut, 4);
    #1;
    chk_lvl(out_en, 1'b0);
    stop_test();
  end

  // hang guard, far beyond the longest expected run
  initial begin
    #500000;
    miscompares++;
    stop_test();
  end
endmodule : ouv_fault_test
`default_nettype wire
